// >>> l1_atomic_excl_cfg.svh
// constants for the l1 data atomic and exclusive control block
`ifndef L1_ATOMIC_EXCL_CFG_SVH
`define L1_ATOMIC_EXCL_CFG_SVH

// ==========================================================
// geometry
`define CFG_NUM_WAYS 4
`define CFG_NUM_LOR_DESC 4
`define CFG_LINE_BYTES 64
`define CFG_GRANULE_WORDS 16
`define CFG_GRANULE_LSB 6

// ==========================================================
// feature identification
`define CFG_ACQ_PC_FIELD_LSB 20
`define CFG_ACQ_PC_FIELD_VAL 4'h1

// ==========================================================
// extended control register fields
`define CFG_ECTL_NEAR_LSB 0
`define CFG_ECTL_WIDTH 8

`endif

// >>> l1_atomic_excl_pkg.sv
// types shared by the l1 data atomic and exclusive control block
package l1_atomic_excl_pkg;

  // ==========================================================
  // atomic route decision
  typedef enum logic [2:0] {
    route_none,
    route_near,
    route_far_l3,
    route_far_icn,
    route_abort
  } route_e;

  // ==========================================================
  // exclusive access opcode classes
  typedef enum logic [2:0] {
    excl_none,
    excl_load,
    excl_load_acq,
    excl_store,
    excl_store_rel,
    excl_clear
  } excl_op_e;

  // ==========================================================
  // line coherence state seen by the atomic logic
  typedef enum logic [1:0] {
    line_invalid,
    line_shared,
    line_unique
  } line_state_e;

endpackage : l1_atomic_excl_pkg

// >>> excl_monitor.sv
// two-state exclusive monitor for load/store-exclusive sequences
`timescale 1ns/100ps
`include "l1_atomic_excl_cfg.svh"
module excl_monitor #(
  parameter int ADDR_W = 48
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  // core requests
  input wire logic op_valid_i,
  input wire l1_atomic_excl_pkg::excl_op_e op_i,
  input wire logic [ADDR_W-1:0] op_addr_i,
  // snoop traffic from other agents
  input wire logic snoop_valid_i,
  input wire logic [ADDR_W-1:0] snoop_addr_i,
  // status
  output logic exclusive_o,
  output logic store_ok_o,
  output logic store_done_o
);
  import l1_atomic_excl_pkg::*;

  typedef enum {mon_open, mon_exclusive} mon_state_e;

  // refused at elaboration: the granule tag would be empty
  if (ADDR_W <= `CFG_GRANULE_LSB) begin : g_addr_check
    $error("excl_monitor: address too narrow");
  end

  // ==========================================================
  // monitor state
  mon_state_e state;
  mon_state_e next_state;
  logic [ADDR_W-1:`CFG_GRANULE_LSB] tag;
  logic [ADDR_W-1:`CFG_GRANULE_LSB] next_tag;
  logic next_store_ok;
  logic next_store_done;
  logic is_load;
  logic is_store;
  logic tag_hit;
  logic snoop_hit;

  always_comb begin
    is_load = op_valid_i && (op_i == excl_load || op_i == excl_load_acq);
    is_store = op_valid_i && (op_i == excl_store || op_i == excl_store_rel);
    tag_hit = op_addr_i[ADDR_W-1:`CFG_GRANULE_LSB] == tag;
    snoop_hit = snoop_valid_i && snoop_addr_i[ADDR_W-1:`CFG_GRANULE_LSB] == tag;
    next_state = state;
    next_tag = tag;
    next_store_ok = 1'b0;
    next_store_done = is_store;
    case (state)
      mon_open: begin
        if (is_load) begin
          next_state = mon_exclusive;
          next_tag = op_addr_i[ADDR_W-1:`CFG_GRANULE_LSB];
        end
      end
      mon_exclusive: begin
        if (is_store) begin
          next_store_ok = tag_hit && !snoop_hit;
          next_state = mon_open;
        end else if (op_valid_i && op_i == excl_clear) begin
          next_state = mon_open;
        end else if (is_load) begin
          next_tag = op_addr_i[ADDR_W-1:`CFG_GRANULE_LSB];
        end else if (snoop_hit) begin
          next_state = mon_open;
        end
      end
      default: next_state = mon_open;
    endcase
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state <= mon_open;
      tag <= '0;
      store_ok_o <= 1'b0;
      store_done_o <= 1'b0;
      exclusive_o <= 1'b0;
    end else begin
      state <= next_state;
      tag <= next_tag;
      store_ok_o <= next_store_ok;
      store_done_o <= next_store_done;
      exclusive_o <= (next_state == mon_exclusive);
    end
  end

  a_store_fail_open: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (is_store && state == mon_open) |=> (store_done_o && !store_ok_o))
    else $error("store-exclusive succeeded from open");
  a_snoop_clears_mon: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (state == mon_exclusive && snoop_hit && !op_valid_i) |=> !exclusive_o)
    else $error("snoop hit left monitor exclusive");
  a_load_sets_mon: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (is_load) |=> exclusive_o)
    else $error("load-exclusive did not set monitor");

endmodule : excl_monitor

// >>> l1_data_atomic_exclusive_ctl.sv
// l1 data-side atomic routing, transient hints and exclusive decode
// ==========================================================
// Summary of operation
// - four-way data cache, virtual index, physical tag
// - four limited-ordering-region descriptors held
// - unique l1 hit runs atomic near
// - miss or shared sends atomic far
// - cluster-wide miss forwards to capable interconnect
// - cluster hit or no support: l3 performs
// - near mode: one fill, loss falls far
// - device/non-cacheable atomic to interconnect or abort
// - feature id bits 23:20 read 0001
// - transient write-back miss allocates line marked transient
// - transient eviction passes hint to l2
// - transient l2 eviction bypasses next level
// - non-temporal write-back loads treated as transient
// - two-state open/exclusive monitor
// - reservation granule is one 64-byte line
// - decode exclusive load/store instruction prefixes
`timescale 1ns/100ps
`include "l1_atomic_excl_cfg.svh"
module l1_data_atomic_exclusive_ctl #(
  parameter int ADDR_W = 48,
  parameter int NUM_WAYS = `CFG_NUM_WAYS,
  parameter int NUM_LOR = `CFG_NUM_LOR_DESC,
  parameter int NUM_ATOMIC_TYPES = `CFG_ECTL_WIDTH
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  // configuration
  input wire logic [NUM_ATOMIC_TYPES-1:0] core_extended_control_reg_i,
  input wire logic icn_atomic_support_i,
  input wire logic l3_present_i,
  // atomic request from the pipeline
  input wire logic atomic_valid_i,
  input wire logic [$clog2(NUM_ATOMIC_TYPES)-1:0] atomic_type_i,
  input wire logic atomic_cacheable_i,
  input wire l1_atomic_excl_pkg::line_state_e atomic_line_state_i,
  input wire logic [$clog2(NUM_WAYS)-1:0] atomic_hit_way_i,
  // far atomic lookup result from the cluster
  input wire logic cluster_resp_valid_i,
  input wire logic cluster_hit_i,
  input wire logic l3_line_present_i,
  // near-mode fill tracking
  input wire logic fill_done_i,
  input wire logic line_lost_i,
  // load/store allocation
  input wire logic ls_miss_valid_i,
  input wire logic ls_transient_i,
  input wire logic ls_nontemporal_load_i,
  input wire logic ls_write_back_i,
  input wire logic [$clog2(NUM_WAYS)-1:0] ls_fill_way_i,
  input wire logic [5:0] ls_fill_set_i,
  input wire logic l1_evict_valid_i,
  input wire logic [$clog2(NUM_WAYS)-1:0] l1_evict_way_i,
  input wire logic [5:0] l1_evict_set_i,
  input wire logic l2_evict_valid_i,
  input wire logic l2_evict_transient_i,
  // limited ordering region descriptor write
  input wire logic lor_we_i,
  input wire logic [$clog2(NUM_LOR)-1:0] lor_idx_i,
  input wire logic [ADDR_W-1:0] lor_base_i,
  // exclusive traffic
  input wire logic instr_valid_i,
  input wire logic [2:0] instr_prefix_i,
  input wire logic [ADDR_W-1:0] instr_addr_i,
  input wire logic snoop_valid_i,
  input wire logic [ADDR_W-1:0] snoop_addr_i,
  // outputs
  output l1_atomic_excl_pkg::route_e route_o,
  output logic route_valid_o,
  output logic fill_req_o,
  output logic abort_o,
  output logic l3_alloc_o,
  output logic [63:0] isa_feature_id_reg_o,
  output logic l2_transient_hint_o,
  output logic l2_evict_bypass_o,
  output logic [ADDR_W-1:0] lor_base_o,
  output logic exclusive_o,
  output logic store_ok_o,
  output logic store_done_o
);
  import l1_atomic_excl_pkg::*;

  // index ports must cover exactly the tables they select from
  if (NUM_WAYS != `CFG_NUM_WAYS || NUM_LOR < 2 || NUM_ATOMIC_TYPES < 2
      || NUM_LOR != (1 << $clog2(NUM_LOR))
      || NUM_ATOMIC_TYPES != (1 << $clog2(NUM_ATOMIC_TYPES))) begin : g_param_check
    $error("l1_data_atomic_exclusive_ctl: unsupported parameters");
  end

  typedef enum {at_idle, at_wait_fill, at_wait_cluster} atomic_state_e;

  // ==========================================================
  // atomic routing
  atomic_state_e state;
  atomic_state_e next_state;
  route_e next_route;
  logic next_route_valid;
  logic next_fill_req;
  logic next_abort;
  logic next_l3_alloc;
  logic want_near;

  always_comb begin
    want_near = core_extended_control_reg_i[atomic_type_i];
    next_state = state;
    next_route = route_none;
    next_route_valid = 1'b0;
    next_fill_req = 1'b0;
    next_abort = 1'b0;
    next_l3_alloc = 1'b0;
    case (state)
      at_idle: begin
        if (atomic_valid_i) begin
          if (!atomic_cacheable_i) begin
            next_route_valid = 1'b1;
            if (icn_atomic_support_i) begin
              next_route = route_far_icn;
            end else begin
              next_route = route_abort;
              next_abort = 1'b1;
            end
          end else if (atomic_line_state_i == line_unique) begin
            next_route = route_near;
            next_route_valid = 1'b1;
          end else if (want_near) begin
            next_fill_req = 1'b1;
            next_state = at_wait_fill;
          end else begin
            next_state = at_wait_cluster;
          end
        end
      end
      at_wait_fill: begin
        if (line_lost_i) begin
          next_state = at_wait_cluster;
        end else if (fill_done_i) begin
          next_route = route_near;
          next_route_valid = 1'b1;
          next_state = at_idle;
        end
      end
      at_wait_cluster: begin
        if (cluster_resp_valid_i) begin
          next_route_valid = 1'b1;
          next_state = at_idle;
          if (!cluster_hit_i && icn_atomic_support_i) begin
            next_route = route_far_icn;
          end else begin
            next_route = route_far_l3;
            next_l3_alloc = l3_present_i && !l3_line_present_i;
          end
        end
      end
      default: next_state = at_idle;
    endcase
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state <= at_idle;
      route_o <= route_none;
      route_valid_o <= 1'b0;
      fill_req_o <= 1'b0;
      abort_o <= 1'b0;
      l3_alloc_o <= 1'b0;
    end else begin
      state <= next_state;
      route_o <= next_route;
      route_valid_o <= next_route_valid;
      fill_req_o <= next_fill_req;
      abort_o <= next_abort;
      l3_alloc_o <= next_l3_alloc;
    end
  end

  // ==========================================================
  // feature identification, constant after reset
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      isa_feature_id_reg_o <= '0;
    end else begin
      isa_feature_id_reg_o <= 64'h0;
      isa_feature_id_reg_o[`CFG_ACQ_PC_FIELD_LSB +: 4] <= `CFG_ACQ_PC_FIELD_VAL;
    end
  end

  // ==========================================================
  // transient markers, one per line of a 64-set four-way array
  // indexing by virtual set, physical tag lives in the tag array outside
  logic [NUM_WAYS-1:0] trans_mark [64];
  logic [NUM_WAYS-1:0] next_trans_mark [64];
  logic fill_transient;
  logic next_hint;
  logic next_bypass;

  always_comb begin
    fill_transient = ls_transient_i || (ls_nontemporal_load_i && ls_write_back_i);
    next_trans_mark = trans_mark;
    next_hint = 1'b0;
    if (l1_evict_valid_i) begin
      next_hint = trans_mark[l1_evict_set_i][l1_evict_way_i];
      next_trans_mark[l1_evict_set_i][l1_evict_way_i] = 1'b0;
    end
    if (ls_miss_valid_i && ls_write_back_i) begin
      next_trans_mark[ls_fill_set_i][ls_fill_way_i] = fill_transient;
    end
    next_bypass = l2_evict_valid_i && l2_evict_transient_i;
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      trans_mark <= '{default: '0};
      l2_transient_hint_o <= 1'b0;
      l2_evict_bypass_o <= 1'b0;
    end else begin
      trans_mark <= next_trans_mark;
      l2_transient_hint_o <= next_hint;
      l2_evict_bypass_o <= next_bypass;
    end
  end

  // ==========================================================
  // limited ordering region descriptors
  logic [ADDR_W-1:0] lor_desc [NUM_LOR];
  logic [ADDR_W-1:0] next_lor_desc [NUM_LOR];

  always_comb begin
    next_lor_desc = lor_desc;
    if (lor_we_i) begin
      next_lor_desc[lor_idx_i] = lor_base_i;
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      lor_desc <= '{default: '0};
      lor_base_o <= '0;
    end else begin
      lor_desc <= next_lor_desc;
      lor_base_o <= lor_desc[lor_idx_i];
    end
  end

  // ==========================================================
  // exclusive decode: prefix code 1..5 maps onto the opcode classes
  excl_op_e excl_op;

  always_comb begin
    case (instr_prefix_i)
      3'h1: excl_op = excl_load;
      3'h2: excl_op = excl_load_acq;
      3'h3: excl_op = excl_store;
      3'h4: excl_op = excl_store_rel;
      3'h5: excl_op = excl_clear;
      default: excl_op = excl_none;
    endcase
  end

  excl_monitor #(
    .ADDR_W(ADDR_W)
  ) u_monitor (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .op_valid_i(instr_valid_i && excl_op != excl_none),
    .op_i(excl_op),
    .op_addr_i(instr_addr_i),
    .snoop_valid_i(snoop_valid_i),
    .snoop_addr_i(snoop_addr_i),
    .exclusive_o(exclusive_o),
    .store_ok_o(store_ok_o),
    .store_done_o(store_done_o)
  );

  // ==========================================================
  // checks
  a_near_unique_hit: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (state == at_idle && atomic_valid_i && atomic_cacheable_i
     && atomic_line_state_i == line_unique) |=> (route_valid_o && route_o == route_near))
    else $error("unique hit not run near");
  a_far_on_miss: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (state == at_idle && atomic_valid_i && atomic_cacheable_i
     && atomic_line_state_i != line_unique && !want_near) |=> state == at_wait_cluster)
    else $error("miss not sent far");
  a_icn_forward: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (state == at_wait_cluster && cluster_resp_valid_i && !cluster_hit_i
     && icn_atomic_support_i) |=> route_o == route_far_icn)
    else $error("cluster miss not forwarded");
  a_l3_perform: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (state == at_wait_cluster && cluster_resp_valid_i
     && (cluster_hit_i || !icn_atomic_support_i)) |=> route_o == route_far_l3)
    else $error("l3 did not take atomic");
  a_loss_goes_far: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (state == at_wait_fill && line_lost_i) |=> (state == at_wait_cluster && !route_valid_o))
    else $error("lost line not sent far");
  a_nc_abort: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (state == at_idle && atomic_valid_i && !atomic_cacheable_i && !icn_atomic_support_i)
    |=> (abort_o && route_o == route_abort))
    else $error("uncached atomic without support not aborted");
  a_feature_id: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    $past(rst_b_i) |-> isa_feature_id_reg_o[23:20] == 4'h1)
    else $error("feature id field wrong");
  a_l2_bypass: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (l2_evict_valid_i && l2_evict_transient_i) |=> l2_evict_bypass_o)
    else $error("transient l2 eviction not bypassed");

  // near mode: request taken, then exactly one fill pulse
  sequence s_near_request;
    state == at_idle && atomic_valid_i && atomic_cacheable_i
      && atomic_line_state_i != line_unique && want_near;
  endsequence
  sequence s_single_fill;
    fill_req_o ##1 !fill_req_o;
  endsequence
  a_one_fill_only: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    s_near_request |=> s_single_fill)
    else $error("near-mode atomic did not make exactly one fill");

endmodule : l1_data_atomic_exclusive_ctl

// >>> fill_partner.sv
// behavioural fill responder standing in for the l2 and cluster
`timescale 1ns/100ps
module fill_partner (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  // control from the bench
  input wire logic lose_line_i,
  input wire logic [3:0] delay_i,
  // fill traffic
  input wire logic fill_req_i,
  output logic fill_done_o,
  output logic line_lost_o
);
  // one answer per request, a second request while waiting is not expected
  initial begin
    fill_done_o = 1'b0;
    line_lost_o = 1'b0;
    forever begin
      @(negedge clock_i);
      if (rst_b_i && fill_req_i) begin
        repeat (delay_i) @(negedge clock_i);
        if (lose_line_i) begin
          line_lost_o <= 1'b1;
        end else begin
          fill_done_o <= 1'b1;
        end
        @(negedge clock_i);
        fill_done_o <= 1'b0;
        line_lost_o <= 1'b0;
      end
    end
  end
endmodule : fill_partner

// >>> l1_data_atomic_exclusive_ctl_tb.sv
// self-checking bench for the l1 data atomic and exclusive control block
`timescale 1ns/100ps
module l1_data_atomic_exclusive_ctl_tb;
  import l1_atomic_excl_pkg::*;
  // ==========================================================
  // signals
  logic clock_i = 1'b0, rst_b_i = 1'b0;
  logic [7:0] core_extended_control_reg_i = 8'h00;
  logic icn_atomic_support_i = 1'b1, l3_present_i = 1'b1;
  logic atomic_valid_i = 1'b0, atomic_cacheable_i = 1'b0;
  logic [2:0] atomic_type_i = 3'h0;
  line_state_e atomic_line_state_i = line_invalid;
  logic cluster_resp_valid_i = 1'b0, cluster_hit_i = 1'b0, l3_line_present_i = 1'b0;
  logic fill_done_i, line_lost_i, lose_line = 1'b0;
  logic [3:0] fill_delay = 4'h0;
  logic ls_miss_valid_i = 1'b0, ls_transient_i = 1'b0, ls_nontemporal_load_i = 1'b0;
  logic ls_write_back_i = 1'b0, l1_evict_valid_i = 1'b0;
  logic l2_evict_valid_i = 1'b0, l2_evict_transient_i = 1'b0;
  logic [1:0] ls_fill_way_i = 2'h0, l1_evict_way_i = 2'h0, lor_idx_i = 2'h0;
  logic [5:0] ls_fill_set_i = 6'h00, l1_evict_set_i = 6'h00;
  logic lor_we_i = 1'b0, instr_valid_i = 1'b0, snoop_valid_i = 1'b0;
  logic [47:0] lor_base_i = 48'h0, instr_addr_i = 48'h0, snoop_addr_i = 48'h0;
  logic [2:0] instr_prefix_i = 3'h0;
  route_e route_o;
  logic route_valid_o, fill_req_o, abort_o, l3_alloc_o, l2_transient_hint_o;
  logic l2_evict_bypass_o, exclusive_o, store_ok_o, store_done_o;
  logic [63:0] isa_feature_id_reg_o;
  logic [47:0] lor_base_o;
  int mismatches = 0, total_checks = 0;
  localparam logic [47:0] ADDR_A = 48'h0000_1234_5640;

  l1_data_atomic_exclusive_ctl dut (
    .clock_i, .rst_b_i, .core_extended_control_reg_i, .icn_atomic_support_i,
    .l3_present_i, .atomic_valid_i, .atomic_type_i, .atomic_cacheable_i,
    .atomic_line_state_i, .atomic_hit_way_i(2'h0), .cluster_resp_valid_i,
    .cluster_hit_i, .l3_line_present_i, .fill_done_i, .line_lost_i, .ls_miss_valid_i,
    .ls_transient_i, .ls_nontemporal_load_i, .ls_write_back_i, .ls_fill_way_i,
    .ls_fill_set_i, .l1_evict_valid_i, .l1_evict_way_i, .l1_evict_set_i,
    .l2_evict_valid_i, .l2_evict_transient_i, .lor_we_i, .lor_idx_i, .lor_base_i,
    .instr_valid_i, .instr_prefix_i, .instr_addr_i, .snoop_valid_i, .snoop_addr_i,
    .route_o, .route_valid_o, .fill_req_o, .abort_o, .l3_alloc_o,
    .isa_feature_id_reg_o, .l2_transient_hint_o, .l2_evict_bypass_o, .lor_base_o,
    .exclusive_o, .store_ok_o, .store_done_o
  );
  fill_partner partner (
    .clock_i, .rst_b_i, .lose_line_i(lose_line), .delay_i(fill_delay),
    .fill_req_i(fill_req_o), .fill_done_o(fill_done_i), .line_lost_o(line_lost_i)
  );

  initial begin
    forever #12.5 clock_i = ~clock_i;
  end

  // ==========================================================
  // shared tasks
  task end_of_test;
    $display("checks=%0d mismatches=%0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_of_test

  task chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic atomic(input logic [2:0] typ, input logic cach, input line_state_e st,
    input logic resp, input logic hit, input logic lp, input route_e exp, input logic xl3);
    int n;
    atomic_type_i = typ;
    atomic_cacheable_i = cach;
    atomic_line_state_i = st;
    atomic_valid_i = 1'b1;
    @(negedge clock_i);
    atomic_valid_i = 1'b0;
    chk(fill_req_o, cach && st != line_unique && core_extended_control_reg_i[typ]);
    if (resp) begin
      // far side answers late, after any near-mode fill has played out
      repeat (6) @(negedge clock_i);
      cluster_hit_i = hit;
      l3_line_present_i = lp;
      cluster_resp_valid_i = 1'b1;
      @(negedge clock_i);
      cluster_resp_valid_i = 1'b0;
      cluster_hit_i = ~hit;
      l3_line_present_i = ~lp;
    end
    n = 0;
    while (route_valid_o !== 1'b1 && n < 12) begin
      @(negedge clock_i);
      n++;
    end
    if (n == 12) begin
      mismatches++;
      $display("[FAIL] t=%0t route_valid=%h exp=%h", $time, route_valid_o, 1'b1);
      end_of_test();
    end else begin
      chk(route_o, exp);
      chk(l3_alloc_o, xl3);
      chk(abort_o, exp == route_abort);
      @(negedge clock_i);
    end
  endtask : atomic

  task automatic fill(input logic [5:0] s, input logic [1:0] w, input logic tr,
    input logic nt, input logic wb);
    ls_fill_set_i = s;
    ls_fill_way_i = w;
    ls_transient_i = tr;
    ls_nontemporal_load_i = nt;
    ls_write_back_i = wb;
    ls_miss_valid_i = 1'b1;
    @(negedge clock_i);
    ls_miss_valid_i = 1'b0;
    @(negedge clock_i);
  endtask : fill

  task automatic evict(input logic [5:0] s, input logic [1:0] w, input logic exp);
    l1_evict_set_i = s;
    l1_evict_way_i = w;
    l1_evict_valid_i = 1'b1;
    @(negedge clock_i);
    l1_evict_valid_i = 1'b0;
    chk(l2_transient_hint_o, exp);
    @(negedge clock_i);
  endtask : evict

  task automatic excl(input logic [2:0] p, input logic [47:0] a, input logic sn,
    input logic xe, input logic xd, input logic xo);
    instr_valid_i = (p != 3'h0);
    instr_prefix_i = p;
    instr_addr_i = a;
    snoop_valid_i = sn;
    snoop_addr_i = a;
    @(negedge clock_i);
    instr_valid_i = 1'b0;
    snoop_valid_i = 1'b0;
    chk(exclusive_o, xe);
    chk(store_done_o, xd);
    chk(store_ok_o, xo);
    @(negedge clock_i);
  endtask : excl

  task automatic l2_evict(input logic tr);
    l2_evict_transient_i = tr;
    l2_evict_valid_i = 1'b1;
    @(negedge clock_i);
    l2_evict_valid_i = 1'b0;
    chk(l2_evict_bypass_o, tr);
    @(negedge clock_i);
  endtask : l2_evict

  task automatic lor_rw;
    for (int i = 0; i < 4; i++) begin
      lor_idx_i = i[1:0];
      lor_base_i = 48'h0000_5a5a_0000 + 48'h1111 * i;
      lor_we_i = 1'b1;
      @(negedge clock_i);
    end
    lor_we_i = 1'b0;
    for (int i = 0; i < 4; i++) begin
      lor_idx_i = i[1:0];
      @(negedge clock_i);
      chk(lor_base_o, 48'h0000_5a5a_0000 + 48'h1111 * i);
    end
  endtask : lor_rw

  // reset in mid-run must drop the reservation
  task automatic mid_reset;
    rst_b_i = 1'b0;
    @(negedge clock_i);
    chk(exclusive_o, 1'b0);
    rst_b_i = 1'b1;
    @(negedge clock_i);
    chk(isa_feature_id_reg_o, 64'h0000_0000_0010_0000);
  endtask : mid_reset

  // ==========================================================
  // main sequence
  initial begin
    repeat (12) @(negedge clock_i);
    rst_b_i = 1'b1;
    @(negedge clock_i);
    chk(isa_feature_id_reg_o, 64'h0000_0000_0010_0000);
    atomic(3'h0, 1'b1, line_unique, 1'b0, 1'b0, 1'b0, route_near, 1'b0);
    atomic(3'h0, 1'b0, line_invalid, 1'b0, 1'b0, 1'b0, route_far_icn, 1'b0);
    icn_atomic_support_i = 1'b0;
    atomic(3'h0, 1'b0, line_invalid, 1'b0, 1'b0, 1'b0, route_abort, 1'b0);
    atomic(3'h2, 1'b1, line_shared, 1'b1, 1'b0, 1'b0, route_far_l3, 1'b1);
    icn_atomic_support_i = 1'b1;
    atomic(3'h1, 1'b1, line_shared, 1'b1, 1'b0, 1'b0, route_far_icn, 1'b0);
    atomic(3'h2, 1'b1, line_invalid, 1'b1, 1'b1, 1'b0, route_far_l3, 1'b1);
    atomic(3'h2, 1'b1, line_invalid, 1'b1, 1'b1, 1'b1, route_far_l3, 1'b0);
    l3_present_i = 1'b0;
    atomic(3'h3, 1'b1, line_invalid, 1'b1, 1'b1, 1'b0, route_far_l3, 1'b0);
    l3_present_i = 1'b1;
    core_extended_control_reg_i = 8'h20;
    fill_delay = 4'h3;
    atomic(3'h5, 1'b1, line_shared, 1'b0, 1'b0, 1'b0, route_near, 1'b0);
    lose_line = 1'b1;
    fill_delay = 4'h0;
    atomic(3'h5, 1'b1, line_shared, 1'b1, 1'b0, 1'b0, route_far_icn, 1'b0);
    atomic(3'h4, 1'b1, line_shared, 1'b1, 1'b0, 1'b0, route_far_icn, 1'b0);
    for (int w = 0; w < 4; w++) fill(6'h05, w[1:0], w[0], 1'b0, 1'b1);
    for (int w = 0; w < 4; w++) evict(6'h05, w[1:0], w[0]);
    fill(6'h07, 2'h2, 1'b0, 1'b1, 1'b1);
    evict(6'h07, 2'h2, 1'b1);
    fill(6'h09, 2'h3, 1'b0, 1'b1, 1'b0);
    evict(6'h09, 2'h3, 1'b0);
    l2_evict(1'b0);
    l2_evict(1'b1);
    lor_rw();
    excl(3'h1, ADDR_A, 1'b0, 1'b1, 1'b0, 1'b0);
    excl(3'h3, ADDR_A + 48'h3c, 1'b0, 1'b0, 1'b1, 1'b1);
    excl(3'h3, ADDR_A, 1'b0, 1'b0, 1'b1, 1'b0);
    excl(3'h2, ADDR_A, 1'b0, 1'b1, 1'b0, 1'b0);
    excl(3'h4, ADDR_A + 48'h40, 1'b0, 1'b0, 1'b1, 1'b0);
    excl(3'h1, ADDR_A, 1'b0, 1'b1, 1'b0, 1'b0);
    excl(3'h5, ADDR_A, 1'b0, 1'b0, 1'b0, 1'b0);
    excl(3'h2, ADDR_A, 1'b0, 1'b1, 1'b0, 1'b0);
    excl(3'h0, ADDR_A + 48'h8, 1'b1, 1'b0, 1'b0, 1'b0);
    excl(3'h1, ADDR_A, 1'b0, 1'b1, 1'b0, 1'b0);
    excl(3'h0, ADDR_A + 48'h80, 1'b1, 1'b1, 1'b0, 1'b0);
    excl(3'h6, ADDR_A, 1'b0, 1'b1, 1'b0, 1'b0);
    excl(3'h4, ADDR_A, 1'b0, 1'b0, 1'b1, 1'b1);
    excl(3'h1, ADDR_A, 1'b0, 1'b1, 1'b0, 1'b0);
    mid_reset();
    end_of_test();
  end
endmodule : l1_data_atomic_exclusive_ctl_tb
